// ---- psq_pkg.sv ----
// Shared constants and types for the program sequencer block.
package psq_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Widths and sizes.
   localparam int PC_W = 12; // Program counter width.
   localparam int PCL_W = 8; // Software-visible low byte width.
   localparam int PAGE_W = 4; // Page number width above the low byte.
   localparam int WORD_W = 16; // Program memory word width.
   localparam int STK_DEPTH = 8; // Return stack levels.
   localparam int STK_PW = 3; // Stack write pointer width.
   localparam int STK_CW = 4; // Stack occupancy counter width.
   localparam int ADDR_W = 3; // Register port address width.
   ////////////////////////////////////////////////////////////////////////////
   // Instruction cycle phases, four machine clocks per instruction cycle.
   localparam logic [1:0] PH_T1 = 2'h0; // Fetch starts, counter has advanced.
   localparam logic [1:0] PH_T4 = 2'h3; // Decoder result is taken here.
   ////////////////////////////////////////////////////////////////////////////
   // Fixed addresses and reset values.
   localparam logic [PC_W-1:0] RESET_VEC = 12'h000; // Start address after reset.
   localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hf; // Page used by the last-page table read.
   localparam logic [STK_CW-1:0] STK_FULL = 4'h8; // Occupancy when every level is used.
   localparam logic [7:0] ACC_RST = 8'h00; // Accumulator reset value.
   localparam logic [3:0] STATUS_RST = 4'h0; // Status flags reset value.
   localparam logic [7:0] TBLP_RST = 8'h00; // Table pointer low reset value.
   localparam logic [3:0] TBHP_RST = 4'h0; // Table pointer high reset value.
   localparam logic [7:0] TABLE_HIGH_RESULT_RST = 8'h00; // Table high result reset value.
   localparam logic [7:0] TABLE_HIGH_RESULT_MASK = 8'hff; // Bits backed by the program word.
   ////////////////////////////////////////////////////////////////////////////
   // Register offsets on the plain register port.
   localparam logic [ADDR_W-1:0] REG_PCL = 3'h0; // Program counter low byte.
   localparam logic [ADDR_W-1:0] REG_TBLP = 3'h1; // Table pointer low.
   localparam logic [ADDR_W-1:0] REG_TBHP = 3'h2; // Table pointer high.
   localparam logic [ADDR_W-1:0] REG_TABLE_HIGH_RESULT = 3'h3; // Table high result, read only.
   localparam logic [ADDR_W-1:0] REG_ACC = 3'h4; // Accumulator.
   localparam logic [ADDR_W-1:0] REG_STATUS = 3'h5; // Status flags.
   ////////////////////////////////////////////////////////////////////////////
   // Status flag positions.
   localparam int ST_C = 0; // Carry, set means no borrow on subtract.
   localparam int ST_AC = 1; // Auxiliary carry from the low nibble.
   localparam int ST_Z = 2; // Result was zero.
   localparam int ST_OV = 3; // Signed overflow.
   ////////////////////////////////////////////////////////////////////////////
   // Instruction classes delivered by the decoder at phase T4.
   typedef enum logic [3:0] {
      OP_NONE, OP_ALU, OP_JUMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN, OP_SKIP,
      OP_TBL_FULL, OP_TBL_PAGE, OP_TBL_LAST
   } psq_op_t;
   // ALU operations; rotates, increments and complement work on the operand.
   typedef enum logic [3:0] {
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DADJ, ALU_AND, ALU_OR, ALU_XOR,
      ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_MOV
   } psq_alu_t;
endpackage

// ---- psq_sequencer.sv ----
// Program sequencer: counter, return stack, table reads, ALU and register port.
//
// Implementation choices: the plain strobed port and the register offsets.
module psq_sequencer #(
   parameter logic [11:0] INT_VECTOR = 12'h004 // Interrupt entry address.
) (
   input wire logic mclk, // Machine clock, 250 MHz.
   input wire logic rst, // Synchronous reset, active high.
   output logic [psq_pkg::PC_W-1:0] pm_addr, // Program memory address.
   input wire logic [psq_pkg::WORD_W-1:0] pm_data, // Program word, sampled at T4.
   output logic [psq_pkg::WORD_W-1:0] instr, // Instruction under execution.
   output logic instr_vld, // High when instr is a real instruction.
   output logic [1:0] phase, // Current phase, 0 is T1.
   input wire psq_pkg::psq_op_t op_kind, // Instruction class, taken at T4.
   input wire logic [psq_pkg::PC_W-1:0] op_target, // Jump or call target.
   input wire psq_pkg::psq_alu_t alu_op, // ALU operation.
   input wire logic [7:0] alu_b, // Memory operand.
   input wire logic alu_to_mem, // Send ALU result to memory.
   input wire logic skip_on_nz, // Skip when result is non-zero instead.
   output logic dm_wr, // One-cycle data memory write pulse.
   output logic [7:0] dm_wdata, // Data memory write value.
   input wire logic int_req, // Enabled, latched interrupt request.
   output logic int_ack, // One-cycle interrupt acknowledge pulse.
   input wire logic [psq_pkg::ADDR_W-1:0] reg_addr, // Register address.
   input wire logic [7:0] reg_wdata, // Register write data.
   input wire logic reg_wr, // Register write strobe.
   input wire logic reg_rd, // Register read strobe.
   output logic [7:0] reg_rdata // Read data, the cycle after the strobe.
);
   import psq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // All state of the block in one record.
   typedef struct packed {
      logic [1:0] ph; // Phase counter.
      logic [PC_W-1:0] pc; // Address being fetched this cycle.
      logic vld; // Executing instruction is real.
      logic tbl; // Second cycle of a table read.
      logic [PC_W-1:0] tbl_addr; // Table read address.
      logic [STK_DEPTH-1:0][PC_W-1:0] stk; // Return stack storage.
      logic [STK_PW-1:0] wp; // Next free stack slot.
      logic [STK_CW-1:0] cnt; // Stack occupancy.
      logic pcl_pend; // Software wrote the low byte.
      logic [7:0] pcl_val; // Value written to the low byte.
      logic [7:0] tblp; // Table pointer low.
      logic [3:0] tbhp; // Table pointer high.
      logic [7:0] table_high_result; // Table high result.
      logic [7:0] acc; // Accumulator.
      logic [3:0] st; // Status flags.
      logic [WORD_W-1:0] instr; // Fetched instruction.
      logic [PC_W-1:0] pm_addr; // Registered memory address.
      logic [7:0] rdata; // Registered read data.
      logic ack; // Interrupt acknowledge pulse.
      logic dm_wr; // Data memory write pulse.
      logic [7:0] dm_wdata; // Data memory write value.
   } psq_state_t;

   psq_state_t s_q; // Registered state.
   psq_state_t s_d; // Next state.
   logic [7:0] alu_r; // ALU result.
   logic [3:0] alu_f; // ALU flags after the operation.
   logic [8:0] sum; // Adder with carry out.
   logic [4:0] nib; // Low nibble adder for auxiliary carry.
   logic [7:0] opb; // Adder second operand, inverted on subtract.
   logic cin; // Adder carry in.
   logic [7:0] adj; // Decimal adjust addend.
   logic t4; // Last phase of the instruction cycle.
   logic take_int; // Interrupt is acknowledged this cycle.
   logic skip_hit; // Skip condition met.
   logic [PC_W-1:0] pc_inc; // Sequential next address.

   ////////////////////////////////////////////////////////////////////////////
   // ALU. The adder serves add, subtract and their carry forms; subtract adds
   // the inverted operand so carry set means no borrow.
   always_comb begin
      opb = alu_b;
      cin = 1'b0;
      adj = 8'h00;
      alu_r = alu_b;
      alu_f = s_q.st;
      case (alu_op)
         ALU_ADC: cin = s_q.st[ST_C];
         ALU_SUB: begin
            opb = ~alu_b;
            cin = 1'b1;
         end
         ALU_SBC: begin
            opb = ~alu_b;
            cin = s_q.st[ST_C];
         end
         default: cin = 1'b0;
      endcase
      sum = {1'b0, s_q.acc} + {1'b0, opb} + {8'h00, cin};
      nib = {1'b0, s_q.acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
      case (alu_op)
         ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
            alu_r = sum[7:0];
            alu_f[ST_C] = sum[8];
            alu_f[ST_AC] = nib[4];
            alu_f[ST_OV] = (s_q.acc[7] == opb[7]) && (sum[7] != s_q.acc[7]);
         end
         ALU_DADJ: begin // Decimal adjust of the accumulator.
            if (s_q.acc[3:0] > 4'h9 || s_q.st[ST_AC]) begin
               adj[3:0] = 4'h6;
            end
            if (s_q.acc[7:4] > 4'h9 || s_q.st[ST_C]) begin
               adj[7:4] = 4'h6;
            end
            alu_r = s_q.acc + adj;
            alu_f[ST_C] = s_q.st[ST_C] || (adj[7:4] != 4'h0);
         end
         ALU_AND: alu_r = s_q.acc & alu_b;
         ALU_OR: alu_r = s_q.acc | alu_b;
         ALU_XOR: alu_r = s_q.acc ^ alu_b;
         ALU_CPL: alu_r = ~alu_b;
         ALU_RR: alu_r = {alu_b[0], alu_b[7:1]};
         ALU_RL: alu_r = {alu_b[6:0], alu_b[7]};
         ALU_RRC: begin // Carry rotates through bit 7.
            alu_r = {s_q.st[ST_C], alu_b[7:1]};
            alu_f[ST_C] = alu_b[0];
         end
         ALU_RLC: begin
            alu_r = {alu_b[6:0], s_q.st[ST_C]};
            alu_f[ST_C] = alu_b[7];
         end
         ALU_INC: alu_r = alu_b + 8'h01;
         ALU_DEC: alu_r = alu_b - 8'h01;
         default: alu_r = alu_b;
      endcase
      alu_f[ST_Z] = (alu_r == 8'h00);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing. Everything that changes the flow is decided at T4 so the new
   // address is on the memory at the next T1.
   always_comb begin
      s_d = s_q;
      t4 = (s_q.ph == PH_T4);
      pc_inc = s_q.pc + 12'h001;
      skip_hit = (alu_r == 8'h00) ^ skip_on_nz;
      take_int = 1'b0;
      s_d.ph = s_q.ph + 2'h1;
      s_d.ack = 1'b0;
      s_d.dm_wr = 1'b0;
      // Register port. A write to the low byte is parked until T4 because it
      // stands for the executing instruction changing the flow.
      if (reg_wr) begin
         case (reg_addr)
            REG_PCL: begin
               s_d.pcl_pend = 1'b1;
               s_d.pcl_val = reg_wdata;
            end
            REG_TBLP: s_d.tblp = reg_wdata;
            REG_TBHP: s_d.tbhp = reg_wdata[3:0];
            REG_ACC: s_d.acc = reg_wdata;
            REG_STATUS: s_d.st = reg_wdata[3:0];
            default: s_d.st = s_q.st; // Table high is read only.
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            REG_PCL: s_d.rdata = s_q.pc[7:0];
            REG_TBLP: s_d.rdata = s_q.tblp;
            REG_TBHP: s_d.rdata = {4'h0, s_q.tbhp};
            REG_TABLE_HIGH_RESULT: s_d.rdata = s_q.table_high_result;
            REG_ACC: s_d.rdata = s_q.acc;
            REG_STATUS: s_d.rdata = {4'h0, s_q.st};
            default: s_d.rdata = 8'h00; // Unmapped reads as zero.
         endcase
      end
      if (t4) begin
         s_d.pc = pc_inc;
         s_d.instr = pm_data;
         s_d.vld = 1'b1;
         s_d.tbl = 1'b0;
         if (s_q.tbl) begin
            // Second table cycle: the slot fetched table data, the held
            // instruction now runs and the counter stays put.
            s_d.pc = s_q.pc;
            s_d.instr = s_q.instr;
            s_d.dm_wr = 1'b1;
            s_d.dm_wdata = pm_data[7:0];
            s_d.table_high_result = pm_data[15:8] & TABLE_HIGH_RESULT_MASK;
         end else if (s_q.pcl_pend) begin
            s_d.pc = {s_q.pc[PC_W-1:PCL_W], s_q.pcl_val};
            s_d.vld = 1'b0;
            s_d.pcl_pend = reg_wr && (reg_addr == REG_PCL);
         end else if (s_q.vld && op_kind != OP_NONE && op_kind != OP_ALU) begin
            case (op_kind)
               OP_JUMP: begin
                  s_d.pc = op_target;
                  s_d.vld = 1'b0;
               end
               OP_CALL: begin
                  s_d.stk[s_q.wp] = s_q.pc;
                  s_d.wp = s_q.wp + 3'h1;
                  s_d.cnt = (s_q.cnt == STK_FULL) ? STK_FULL : s_q.cnt + 4'h1;
                  s_d.pc = op_target;
                  s_d.vld = 1'b0;
               end
               OP_RET, OP_INTERRUPT_RETURN: begin
                  s_d.pc = s_q.stk[s_q.wp - 3'h1];
                  s_d.vld = 1'b0;
                  if (s_q.cnt != 4'h0) begin
                     s_d.wp = s_q.wp - 3'h1;
                     s_d.cnt = s_q.cnt - 4'h1;
                  end
               end
               OP_SKIP: begin
                  if (alu_to_mem) begin
                     s_d.dm_wr = 1'b1;
                     s_d.dm_wdata = alu_r;
                  end else begin
                     s_d.acc = alu_r;
                  end
                  s_d.vld = !skip_hit;
               end
               default: begin // Table reads of three address kinds.
                  s_d.tbl = 1'b1;
                  s_d.vld = 1'b0;
                  case (op_kind)
                     OP_TBL_PAGE: s_d.tbl_addr = {s_q.pc[PC_W-1:PCL_W], s_q.tblp};
                     OP_TBL_LAST: s_d.tbl_addr = {LAST_PAGE, s_q.tblp};
                     default: s_d.tbl_addr = {s_q.tbhp, s_q.tblp};
                  endcase
               end
            endcase
         end else begin
            if (s_q.vld && op_kind == OP_ALU) begin
               s_d.st = alu_f;
               if (alu_to_mem) begin
                  s_d.dm_wr = 1'b1;
                  s_d.dm_wdata = alu_r;
               end else begin
                  s_d.acc = alu_r;
               end
            end
            // Interrupt entry replaces the prefetched instruction; it waits
            // while all levels are in use so no return address is lost.
            if (int_req && s_q.cnt != STK_FULL) begin
               take_int = 1'b1;
               s_d.stk[s_q.wp] = s_q.pc;
               s_d.wp = s_q.wp + 3'h1;
               s_d.cnt = s_q.cnt + 4'h1;
               s_d.pc = INT_VECTOR;
               s_d.vld = 1'b0;
               s_d.ack = 1'b1;
            end
         end
         s_d.pm_addr = s_d.tbl ? s_d.tbl_addr : s_d.pc;
      end
      if (rst) begin
         s_d = '0;
         s_d.pc = RESET_VEC;
         s_d.pm_addr = RESET_VEC;
         s_d.wp = 3'h0;
         s_d.cnt = 4'h0;
         s_d.acc = ACC_RST;
         s_d.st = STATUS_RST;
         s_d.tblp = TBLP_RST;
         s_d.tbhp = TBHP_RST;
         s_d.table_high_result = TABLE_HIGH_RESULT_RST;
      end
   end

   // State register; the stack storage is never reachable from the port.
   always_ff @(posedge mclk) begin
      s_q <= s_d;
   end

   assign pm_addr = s_q.pm_addr;
   assign instr = s_q.instr;
   assign instr_vld = s_q.vld;
   assign phase = s_q.ph;
   assign dm_wr = s_q.dm_wr;
   assign dm_wdata = s_q.dm_wdata;
   assign int_ack = s_q.ack;
   assign reg_rdata = s_q.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the sequencing.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_seq_inc;
      t4 && s_q.vld && !s_q.tbl && !s_q.pcl_pend && op_kind == OP_ALU && !int_req
         |=> s_q.pc == $past(s_q.pc) + 12'h001;
   endproperty
   a_seq_inc: assert property (p_seq_inc) else $error("pc did not step by one");

   property p_jump;
      t4 && s_q.vld && !s_q.tbl && !s_q.pcl_pend && op_kind == OP_JUMP
         |=> (s_q.pc == $past(op_target) && !s_q.vld) [*4] ##1 s_q.vld;
   endproperty
   a_jump: assert property (p_jump) else $error("jump target or dummy cycle wrong");

   property p_pcl;
      t4 && !s_q.tbl && s_q.pcl_pend
         |=> s_q.pc == {$past(s_q.pc[11:8]), $past(s_q.pcl_val)} && !s_q.vld;
   endproperty
   a_pcl: assert property (p_pcl) else $error("low byte jump left page or no dummy");

   property p_int_full;
      s_q.cnt == STK_FULL |=> !s_q.ack;
   endproperty
   a_int_full: assert property (p_int_full) else $error("acknowledge with full stack");

   property p_call_push;
      t4 && s_q.vld && !s_q.tbl && !s_q.pcl_pend && op_kind == OP_CALL
         |=> s_q.cnt == (($past(s_q.cnt) == STK_FULL) ? STK_FULL : $past(s_q.cnt) + 4'h1);
   endproperty
   a_call_push: assert property (p_call_push) else $error("call did not push");

   // Reset must not disable its own check, or the antecedent could never be seen.
   property p_reset;
      @(posedge mclk) disable iff (1'b0)
         rst |=> s_q.pc == RESET_VEC && s_q.cnt == 4'h0 && pm_addr == RESET_VEC;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");

   property p_tbl;
      t4 && s_q.tbl |=> dm_wr && (s_q.table_high_result == $past(pm_data[15:8])) ##4 !dm_wr;
   endproperty
   a_tbl: assert property (p_tbl) else $error("table data not delivered");

   property p_phase;
      s_q.ph == PH_T4 |=> s_q.ph == PH_T1 ##3 s_q.ph == PH_T4;
   endproperty
   a_phase: assert property (p_phase) else $error("instruction cycle not four phases");

   property p_ret_empty;
      t4 && s_q.vld && !s_q.tbl && !s_q.pcl_pend && op_kind == OP_RET && s_q.cnt == 4'h0
         |=> s_q.cnt == 4'h0 && s_q.wp == $past(s_q.wp);
   endproperty
   a_ret_empty: assert property (p_ret_empty) else $error("empty return moved pointer");

   c_call: cover property (t4 && s_q.vld && op_kind == OP_CALL);
   c_int: cover property (s_q.ack);
   c_tbl: cover property (s_q.tbl ##4 dm_wr);
   c_full: cover property (s_q.cnt == STK_FULL && int_req);
endmodule

// ---- psq_pm_model.sv ----
// Program memory model that answers the fetch and table address of the sequencer.
module psq_pm_model (
   input wire logic [psq_pkg::PC_W-1:0] pm_addr, // Word address from the sequencer.
   output logic [psq_pkg::WORD_W-1:0] pm_data // Word stored at that address.
);
   import psq_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // Every word is a scramble of its own address, so a wrong fetch shows.
   // Twelve address bits reach 4K words of 16 bits each.
   assign pm_data = {pm_addr[7:0] ^ 8'h3c, pm_addr[11:4]};
endmodule

// ---- program_sequencer_stack_table_read_tb_top.sv ----
// Self-checking bench for the program sequencer with a program memory model.
module program_sequencer_stack_table_read_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import psq_pkg::*;
   typedef struct packed {psq_alu_t a; logic [7:0] acc, b, y; logic c;} psq_tv_t;
   localparam logic [11:0] IVEC = 12'h0c8; // Interrupt entry used by this bench.
   // One row per ALU operation: operation, accumulator, operand, result, carry in.
   localparam psq_tv_t TV [16] = '{
      '{ALU_ADD, 8'hff, 8'h01, 8'h00, 1'b0}, '{ALU_ADC, 8'h10, 8'h01, 8'h12, 1'b1},
      '{ALU_SUB, 8'h10, 8'h01, 8'h0f, 1'b0}, '{ALU_SBC, 8'h10, 8'h01, 8'h0e, 1'b0},
      '{ALU_DADJ, 8'h0a, 8'h0a, 8'h10, 1'b0}, '{ALU_AND, 8'h0f, 8'h3c, 8'h0c, 1'b0},
      '{ALU_OR, 8'h0f, 8'h30, 8'h3f, 1'b0}, '{ALU_XOR, 8'h0f, 8'hff, 8'hf0, 1'b0},
      '{ALU_CPL, 8'h00, 8'h5a, 8'ha5, 1'b0}, '{ALU_RR, 8'h00, 8'h81, 8'hc0, 1'b0},
      '{ALU_RRC, 8'h00, 8'h81, 8'h40, 1'b0}, '{ALU_RL, 8'h00, 8'h81, 8'h03, 1'b0},
      '{ALU_RLC, 8'h00, 8'h80, 8'h01, 1'b1}, '{ALU_INC, 8'h00, 8'hff, 8'h00, 1'b0},
      '{ALU_DEC, 8'h00, 8'h00, 8'hff, 1'b0}, '{ALU_MOV, 8'h00, 8'h3c, 8'h3c, 1'b0}};
   logic mclk = 1'b0; // Machine clock.
   logic rst = 1'b1; // Synchronous reset.
   logic [11:0] pm_addr, op_target = 12'h0, pa; // Fetch address, target, address at issue.
   logic [15:0] pm_data, instr; // Program word and executing word.
   logic instr_vld, dm_wr, int_ack, alu_to_mem = 1'b0, skip_on_nz = 1'b0, int_req = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0; // Register strobes.
   logic [1:0] phase; // Phase within the instruction cycle.
   logic [7:0] dm_wdata, reg_rdata, alu_b = 8'h00, reg_wdata = 8'h00; // Data paths.
   logic [2:0] reg_addr = 3'h0; // Register address.
   psq_op_t op_kind = OP_NONE; // Decoder class.
   psq_alu_t alu_op = ALU_MOV; // Decoder ALU operation.
   logic [11:0] ra [0:8]; // Return addresses pushed by the calls.
   int bad_count = 0, checks_done = 0, ack_cnt = 0; // Counters.
   always #2 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////
   // The interrupt source drops its request once it is acknowledged.
   always @(posedge mclk) begin
      if (int_ack === 1'b1) begin
         ack_cnt++;
         int_req <= 1'b0;
      end
   end
   psq_sequencer #(.INT_VECTOR(IVEC)) dut_u (.mclk(mclk), .rst(rst), .pm_addr(pm_addr),
      .pm_data(pm_data), .instr(instr), .instr_vld(instr_vld), .phase(phase),
      .op_kind(op_kind), .op_target(op_target), .alu_op(alu_op), .alu_b(alu_b),
      .alu_to_mem(alu_to_mem), .skip_on_nz(skip_on_nz), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
      .int_req(int_req), .int_ack(int_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   psq_pm_model pm_u (.pm_addr(pm_addr), .pm_data(pm_data));
   ////////////////////////////////////////////////////////////////////////////
   // Expected memory contents, kept apart from the model on purpose.
   function automatic logic [15:0] pmw(input logic [11:0] a);
      return {a[7:0] ^ 8'h3c, a[11:4]};
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One-cycle register write; the next access starts an edge later.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // Read data appear in the cycle after the strobe and hold until the next read, so look there.
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(16'(reg_rdata), 16'(e));
   endtask
   // Stops at the edge that ends phase p; a long wait counts as a mismatch.
   task automatic ph(input logic [1:0] p, input logic need_vld);
      int n;
      n = 0;
      @(posedge mclk);
      while (!(phase === p && (instr_vld === 1'b1 || !need_vld))) begin
         n++;
         if (n > 40) begin
            bad_count++;
            $display("BAD %0t no phase %0d", $time, p);
            stop_test();
         end
         @(posedge mclk);
      end
   endtask
   // Presents a decoder result through phase T4 of a real instruction.
   task automatic op(input psq_op_t k, input logic [11:0] tg = 12'h0,
      input psq_alu_t a = ALU_MOV, input logic [7:0] b = 8'h0, input logic m = 1'b0,
      input logic nz = 1'b0);
      ph(2'h2, 1'b1);
      op_kind <= k;
      op_target <= tg;
      alu_op <= a;
      alu_b <= b;
      alu_to_mem <= m;
      skip_on_nz <= nz;
      pa = pm_addr;
      ph(2'h3, 1'b0);
      op_kind <= OP_NONE;
      alu_to_mem <= 1'b0;
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [11:0] ta;
      logic [15:0] w;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      #1 chk(16'(pm_addr), 16'h0);
      for (int i = 0; i < 3; i++) begin
         ph(2'h3, 1'b0);
         #1 chk(instr, pmw(12'(i)));
         chk(16'({phase, pm_addr}), 16'(i + 1));
      end
      op(OP_JUMP, 12'h3f0);
      chk(16'({instr_vld, pm_addr}), 16'h03f0);
      ph(2'h3, 1'b0);
      #1 chk(16'({instr_vld, pm_addr}), 16'h13f1);
      wr(REG_PCL, 8'h20);
      ph(2'h3, 1'b0);
      #1 chk(16'({instr_vld, pm_addr}), 16'h0320);
      rd(REG_PCL, 8'h20);
      wr(REG_TABLE_HIGH_RESULT, 8'h55);
      rd(REG_TABLE_HIGH_RESULT, 8'h00);
      rd(3'h6, 8'h00);
      wr(REG_TBLP, 8'h06);
      wr(REG_TBHP, 8'hf2);
      rd(REG_TBHP, 8'h02);
      for (int i = 0; i < 3; i++) begin
         op(i == 0 ? OP_TBL_FULL : i == 1 ? OP_TBL_PAGE : OP_TBL_LAST);
         ta = i == 0 ? 12'h206 : i == 1 ? {pa[11:8], 8'h06} : 12'hf06;
         w = pmw(ta);
         chk(16'({instr_vld, pm_addr}), 16'(ta));
         ph(2'h3, 1'b0);
         #1 chk(16'({dm_wr, dm_wdata}), 16'({1'b1, w[7:0]}));
         rd(REG_TABLE_HIGH_RESULT, w[15:8]);
      end
      for (int i = 0; i < 16; i++) begin
         wr(REG_ACC, TV[i].acc);
         wr(REG_STATUS, {7'h0, TV[i].c});
         op(OP_ALU, 12'h0, TV[i].a, TV[i].b);
         rd(REG_ACC, TV[i].y);
         if (i == 0) rd(REG_STATUS, 8'h07);
      end
      op(OP_ALU, 12'h0, ALU_MOV, 8'h77, 1'b1);
      chk(16'({dm_wr, dm_wdata}), 16'h0177);
      for (int nz = 0; nz < 2; nz++) begin
         op(OP_SKIP, 12'h0, ALU_INC, 8'hff, 1'b0, nz[0]);
         chk(16'({instr_vld, pm_addr}), 16'({nz[0], pa + 12'h1}));
      end
      for (int i = 0; i < 9; i++) begin
         op(OP_CALL, 12'h100 + 12'(i * 16));
         ra[i] = pa;
         chk(16'(pm_addr), 16'h100 + 16'(i * 16));
      end
      @(posedge mclk);
      int_req <= 1'b1;
      ph(2'h3, 1'b0);
      ph(2'h3, 1'b0);
      #1 chk(16'(ack_cnt), 16'h0);
      op(OP_RET);
      chk(16'(pm_addr), 16'(ra[8]));
      ph(2'h3, 1'b0);
      #1 chk(16'({int_ack, pm_addr}), 16'({1'b1, IVEC}));
      op(OP_INTERRUPT_RETURN);
      for (int k = 7; k > 0; k--) begin
         op(OP_RET);
         chk(16'(pm_addr), 16'(ra[k]));
      end
      op(OP_RET);
      chk(16'(instr_vld), 16'h0);
      op(OP_JUMP, 12'h0a0);
      chk(16'(pm_addr), 16'h00a0);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      #1 chk(16'({instr_vld, pm_addr}), 16'h0);
      stop_test();
   end
endmodule
